/* core/epd_params.svh */
`ifndef EPD_PARAMS_SVH
`define EPD_PARAMS_SVH
// ****************************************
// command codes
// ****************************************
`define CMD_ACTIVATE   8'h20
`define CMD_SEQ_OPT    8'h22
`define CMD_WR_MONO    8'h24
`define CMD_WR_RED     8'h26
`define CMD_RD_RAM     8'h27
`define CMD_SENSE      8'h28
`define CMD_SENSE_DUR  8'h29
`define CMD_PROG_CEV   8'h2A
`define CMD_CEV_CTRL   8'h2B
`define CMD_WR_CEV     8'h2C
`define CMD_CRC_CALC   8'h34
`define CMD_CRC_READ   8'h35
`define CMD_PROG_OPT   8'h36
`define CMD_DISP_OPT   8'h37
`define CMD_USER_ID    8'h38
`define CMD_PROG_MODE  8'h39
`define CMD_BORDER     8'h3C
`define CMD_RD_OPT     8'h41
`define CMD_X_WIN      8'h44
`define CMD_X_CNT      8'h4E
`define CMD_Y_CNT      8'h4F
// ****************************************
// reset values and fields
// ****************************************
`define SEQ_OPT_RST    8'hFF
`define BORDER_RST     8'hC0
`define X_START_RST    10'h000
`define X_END_RST      10'h3BF
`define ADDR_RST       10'h000
`define SENSE_DUR_RST  4'h9
`define SENSE_MODE_BIT 6
`define SEQ_MODE2_BIT  3
`define OPT_BYTES      10
`define OPT_TOTAL      20
`define OPT_BYTE_F     5
`define OPT_PP1_BIT    7
`define OPT_PP2_BIT    6
// ****************************************
// timing
// ****************************************
`define CLK_MHZ        10
`define CLK_HZ         10000000
`define SEQ_STEP_NS    1000
`define SEQ_STEP_CYC   ((`SEQ_STEP_NS * `CLK_MHZ + 999) / 1000)
`endif

/* core/epd_pkg.sv */
package epd_pkg;
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_RUN  = 3'b010,
    SEQ_WAIT = 3'b100
  } seq_state_t;
  typedef enum logic [2:0] {
    OP_IDLE  = 3'b001,
    OP_SENSE = 3'b010,
    OP_OTP   = 3'b100
  } op_state_t;
  typedef enum logic [1:0] {
    OTP_NONE = 2'h0,
    OTP_CEV  = 2'h1,
    OTP_OPT  = 2'h2,
    OTP_CRC  = 2'h3
  } otp_op_t;
endpackage : epd_pkg

/* core/epd_controller_command_decoder.sv */
`timescale 1ns/1ns
`default_nettype none
`include "epd_params.svh"
module epd_controller_command_decoder #(
  parameter int unsigned CYC_PER_SEC = `CLK_HZ
) (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  input  wire logic        cs_n_i,
  input  wire logic        dc_i,
  output logic             busy_o,
  output logic             clock_enable_flag_o,
  output logic             analog_enable_flag_o,
  output logic             display_start_o,
  output logic             display_mode2_o,
  output logic             table_load_o,
  output logic             temp_fetch_o,
  output logic             ram_wr_valid_o,
  input  wire logic        ram_wr_ready_i,
  output logic             ram_wr_plane_o,
  output logic [9:0]       ram_wr_x_o,
  output logic [9:0]       ram_wr_y_o,
  output logic [7:0]       ram_wr_data_o,
  output logic [9:0]       ram_rd_x_o,
  output logic [9:0]       ram_rd_y_o,
  output logic             ram_rd_plane_o,
  input  wire logic [7:0]  ram_rd_data_i,
  input  wire logic [7:0]  sense_value_i,
  output logic [7:0]       common_voltage_o,
  output logic [1:0]       otp_op_o,
  input  wire logic        otp_done_i,
  input  wire logic [15:0] otp_crc_i,
  input  wire logic [4:0]  otp_byte_idx_i,
  output logic [7:0]       otp_byte_o,
  output logic [1:0]       prog_mode_o,
  output logic [7:0]       border_drive_output_o,
  output logic             pingpong_mode1_o,
  output logic             pingpong_mode2_o,
  output logic [9:0]       window_x_start_o,
  output logic [9:0]       window_x_end_o
);
  // ****************************************
  // link sampling
  // ****************************************
  logic [3:0] sync1_reg, sync2_reg;
  logic       scl_d_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] shift_reg, tx_reg, tx_hold_reg;
  logic       rx_valid_reg, rx_dc_reg;
  logic [7:0] rx_byte_reg;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync1_reg <= 4'h7;
      sync2_reg <= 4'h7;
      scl_d_reg <= 1'b0;
    end else begin
      sync1_reg <= {scl_i, sda_i, cs_n_i, dc_i};
      sync2_reg <= sync1_reg;
      scl_d_reg <= sync2_reg[3];
    end
  end
  wire scl_s    = sync2_reg[3];
  wire sda_s    = sync2_reg[2];
  wire cs_n_s   = sync2_reg[1];
  wire dc_s     = sync2_reg[0];
  wire scl_rise = scl_s & ~scl_d_reg & ~cs_n_s;
  wire scl_fall = ~scl_s & scl_d_reg & ~cs_n_s;
  wire byte_end = scl_rise & (bit_cnt_reg == 3'h7);
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bit_cnt_reg <= 3'h0;
      shift_reg   <= 8'h00;
    end else if (cs_n_s) begin
      bit_cnt_reg <= 3'h0;
    end else if (scl_rise) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      shift_reg   <= {shift_reg[6:0], sda_s};
    end
  end
  // ****************************************
  // decoder state
  // ****************************************
  logic [7:0]  cmd_reg, seq_opt_reg;
  logic [3:0]  idx_reg;
  logic        read_mode;
  logic        head_v_reg, tail_v_reg;
  logic [28:0] head_reg, tail_reg;
  logic [9:0]  x_reg, y_reg;
  logic        rd_plane_reg;
  logic [3:0]  sense_dur_reg;
  logic        sense_norm_reg;
  logic [15:0] crc_reg;
  logic [7:0]  opt_mem [0:`OPT_TOTAL-1];
  epd_pkg::seq_state_t seq_state_reg;
  epd_pkg::op_state_t  op_state_reg;
  logic [2:0]  step_idx_reg;
  logic [31:0] wait_cnt_reg;
  logic [3:0]  sec_cnt_reg;
  wire wr_cmd  = (cmd_reg == `CMD_WR_MONO) | (cmd_reg == `CMD_WR_RED);
  wire stall   = rx_dc_reg & wr_cmd & tail_v_reg;
  wire take    = rx_valid_reg & ~stall;
  wire is_cmd  = take & ~rx_dc_reg;
  wire is_dat  = take & rx_dc_reg;
  wire [7:0] b = rx_byte_reg;
  assign read_mode = (cmd_reg == `CMD_RD_RAM) | (cmd_reg == `CMD_CRC_READ);
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_valid_reg <= 1'b0;
      rx_dc_reg    <= 1'b0;
      rx_byte_reg  <= 8'h00;
    end else if (byte_end) begin
      rx_valid_reg <= 1'b1;
      rx_dc_reg    <= dc_s;
      rx_byte_reg  <= {shift_reg[6:0], sda_s};
    end else if (take) begin
      rx_valid_reg <= 1'b0;
    end
  end
  // ****************************************
  // read path
  // ****************************************
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_reg   <= 8'h00;
      sda_o    <= 1'b0;
      sda_oe_o <= 1'b0;
    end else begin
      sda_oe_o <= read_mode & ~cs_n_s & dc_s;
      if (scl_fall && bit_cnt_reg == 3'h0) begin
        sda_o  <= tx_hold_reg[7];
        tx_reg <= {tx_hold_reg[6:0], 1'b0};
      end else if (scl_fall) begin
        sda_o  <= tx_reg[7];
        tx_reg <= {tx_reg[6:0], 1'b0};
      end
    end
  end
  wire cmd_rd   = is_cmd & (b == `CMD_RD_RAM);
  wire cmd_crc  = is_cmd & (b == `CMD_CRC_READ);
  wire dat_rd   = is_dat & (cmd_reg == `CMD_RD_RAM);
  wire dat_crc  = is_dat & (cmd_reg == `CMD_CRC_READ) & (idx_reg == 4'h0);
  wire [7:0] tx_next = cmd_rd  ? 8'h00 :
                       cmd_crc ? crc_reg[15:8] :
                       dat_rd  ? ram_rd_data_i :
                       dat_crc ? crc_reg[7:0] : 8'h00;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) tx_hold_reg <= 8'h00;
    else if (take) tx_hold_reg <= tx_next;
  end
  // ****************************************
  // write buffer and address counter
  // ****************************************
  wire        push    = is_dat & wr_cmd;
  wire        pop     = head_v_reg & ram_wr_ready_i;
  wire [28:0] entry   = {cmd_reg == `CMD_WR_RED, x_reg, y_reg, b};
  wire        advance = push | dat_rd;
  wire        x_wrap  = (x_reg == window_x_end_o);
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      head_v_reg <= 1'b0;
      tail_v_reg <= 1'b0;
      head_reg   <= 29'h0;
      tail_reg   <= 29'h0;
    end else if (pop) begin
      head_v_reg <= tail_v_reg | push;
      head_reg   <= tail_v_reg ? tail_reg : entry;
      tail_v_reg <= tail_v_reg & push;
      if (push) tail_reg <= entry;
    end else if (push && !head_v_reg) begin
      head_v_reg <= 1'b1;
      head_reg   <= entry;
    end else if (push) begin
      tail_v_reg <= 1'b1;
      tail_reg   <= entry;
    end
  end
  assign ram_wr_valid_o = head_v_reg;
  assign ram_wr_plane_o = head_reg[28];
  assign ram_wr_x_o     = head_reg[27:18];
  assign ram_wr_y_o     = head_reg[17:8];
  assign ram_wr_data_o  = head_reg[7:0];
  assign ram_rd_x_o     = x_reg;
  assign ram_rd_y_o     = y_reg;
  assign ram_rd_plane_o = rd_plane_reg;
  wire dat_x = is_dat & (cmd_reg == `CMD_X_CNT);
  wire dat_y = is_dat & (cmd_reg == `CMD_Y_CNT);
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      x_reg <= `ADDR_RST;
      y_reg <= `ADDR_RST;
    end else if (dat_x || dat_y) begin
      if (dat_x && idx_reg == 4'h0) x_reg[7:0] <= b;
      if (dat_x && idx_reg == 4'h1) x_reg[9:8] <= b[1:0];
      if (dat_y && idx_reg == 4'h0) y_reg[7:0] <= b;
      if (dat_y && idx_reg == 4'h1) y_reg[9:8] <= b[1:0];
    end else if (advance) begin
      x_reg <= x_wrap ? window_x_start_o : x_reg + 10'h001;
      if (x_wrap) y_reg <= y_reg + 10'h001;
    end
  end
  // ****************************************
  // parameter registers
  // ****************************************
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cmd_reg               <= 8'h00;
      idx_reg               <= 4'h0;
      seq_opt_reg           <= `SEQ_OPT_RST;
      rd_plane_reg          <= 1'b0;
      sense_dur_reg         <= `SENSE_DUR_RST;
      sense_norm_reg        <= 1'b1;
      prog_mode_o           <= 2'h0;
      border_drive_output_o <= `BORDER_RST;
      window_x_start_o      <= `X_START_RST;
      window_x_end_o        <= `X_END_RST;
      pingpong_mode1_o      <= 1'b0;
      pingpong_mode2_o      <= 1'b0;
    end else if (is_cmd) begin
      cmd_reg <= b;
      idx_reg <= 4'h0;
    end else if (is_dat) begin
      if (idx_reg != 4'hF) idx_reg <= idx_reg + 4'h1;
      case (cmd_reg)
        `CMD_SEQ_OPT:   seq_opt_reg <= b;
        `CMD_RD_OPT:    rd_plane_reg <= b[0];
        `CMD_SENSE_DUR: begin
          sense_dur_reg  <= b[3:0];
          sense_norm_reg <= b[`SENSE_MODE_BIT];
        end
        `CMD_PROG_MODE: prog_mode_o <= b[1:0];
        `CMD_BORDER:    border_drive_output_o <= b;
        `CMD_DISP_OPT: begin
          if (idx_reg == 4'(`OPT_BYTE_F)) begin
            pingpong_mode1_o <= b[`OPT_PP1_BIT];
            pingpong_mode2_o <= b[`OPT_PP2_BIT];
          end
        end
        `CMD_X_WIN: begin
          if (idx_reg == 4'h0) window_x_start_o[7:0] <= b;
          if (idx_reg == 4'h1) window_x_start_o[9:8] <= b[1:0];
          if (idx_reg == 4'h2) window_x_end_o[7:0]   <= b;
          if (idx_reg == 4'h3) window_x_end_o[9:8]   <= b[1:0];
        end
        default: ;
      endcase
    end
  end
  wire opt_wr = is_dat & (idx_reg < 4'(`OPT_BYTES)) &
                ((cmd_reg == `CMD_DISP_OPT) | (cmd_reg == `CMD_USER_ID));
  wire [4:0] opt_addr = (cmd_reg == `CMD_USER_ID) ? 5'(idx_reg) + 5'(`OPT_BYTES) : 5'(idx_reg);
  always_ff @(posedge clk_i) begin
    if (opt_wr) opt_mem[opt_addr] <= b;
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) otp_byte_o <= 8'h00;
    else if (otp_byte_idx_i < 5'(`OPT_TOTAL)) otp_byte_o <= opt_mem[otp_byte_idx_i];
    else otp_byte_o <= 8'h00;
  end
  // ****************************************
  // update sequencer
  // ****************************************
  wire seq_go   = is_cmd & (b == `CMD_ACTIVATE) & (seq_state_reg == epd_pkg::SEQ_IDLE);
  wire step_on  = seq_opt_reg[step_idx_reg] & (step_idx_reg != 3'(`SEQ_MODE2_BIT));
  wire wait_end = (wait_cnt_reg == 32'h0);
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      seq_state_reg        <= epd_pkg::SEQ_IDLE;
      step_idx_reg         <= 3'h7;
      clock_enable_flag_o  <= 1'b0;
      analog_enable_flag_o <= 1'b0;
      display_start_o      <= 1'b0;
      display_mode2_o      <= 1'b0;
      table_load_o         <= 1'b0;
      temp_fetch_o         <= 1'b0;
    end else begin
      display_start_o <= 1'b0;
      table_load_o    <= 1'b0;
      temp_fetch_o    <= 1'b0;
      case (seq_state_reg)
        epd_pkg::SEQ_IDLE: if (seq_go) begin
          seq_state_reg <= epd_pkg::SEQ_RUN;
          step_idx_reg  <= 3'h7;
        end
        epd_pkg::SEQ_RUN: begin
          display_mode2_o <= seq_opt_reg[`SEQ_MODE2_BIT];
          if (step_on) begin
            seq_state_reg <= epd_pkg::SEQ_WAIT;
            case (step_idx_reg)
              3'h7: clock_enable_flag_o  <= 1'b1;
              3'h6: analog_enable_flag_o <= 1'b1;
              3'h5: temp_fetch_o         <= 1'b1;
              3'h4: table_load_o         <= 1'b1;
              3'h2: display_start_o      <= 1'b1;
              3'h1: analog_enable_flag_o <= 1'b0;
              3'h0: clock_enable_flag_o  <= 1'b0;
              default: ;
            endcase
          end else if (step_idx_reg == 3'h0) seq_state_reg <= epd_pkg::SEQ_IDLE;
          else step_idx_reg <= step_idx_reg - 3'h1;
        end
        epd_pkg::SEQ_WAIT: if (wait_end && op_state_reg != epd_pkg::OP_SENSE) begin
          seq_state_reg <= (step_idx_reg == 3'h0) ? epd_pkg::SEQ_IDLE : epd_pkg::SEQ_RUN;
          if (step_idx_reg != 3'h0) step_idx_reg <= step_idx_reg - 3'h1;
        end
        default: seq_state_reg <= epd_pkg::SEQ_IDLE;
      endcase
    end
  end
  // ****************************************
  // sensing and otp operations
  // ****************************************
  wire sense_go = is_cmd & (b == `CMD_SENSE) & clock_enable_flag_o &
                  analog_enable_flag_o & sense_norm_reg;
  wire otp_cev  = is_cmd & (b == `CMD_PROG_CEV) & clock_enable_flag_o;
  wire otp_opt  = is_cmd & (b == `CMD_PROG_OPT) & clock_enable_flag_o;
  wire otp_crc  = is_cmd & (b == `CMD_CRC_CALC);
  wire op_free  = (op_state_reg == epd_pkg::OP_IDLE);
  wire sec_tick = (wait_cnt_reg == 32'h0);
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) wait_cnt_reg <= 32'h0;
    else if (step_on && seq_state_reg == epd_pkg::SEQ_RUN)
      wait_cnt_reg <= 32'(`SEQ_STEP_CYC - 1);
    else if (sense_go && op_free) wait_cnt_reg <= 32'(CYC_PER_SEC - 1);
    else if (op_state_reg == epd_pkg::OP_SENSE && sec_tick) wait_cnt_reg <= 32'(CYC_PER_SEC - 1);
    else if (!wait_end) wait_cnt_reg <= wait_cnt_reg - 32'h1;
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      op_state_reg     <= epd_pkg::OP_IDLE;
      sec_cnt_reg      <= 4'h0;
      otp_op_o         <= epd_pkg::OTP_NONE;
      crc_reg          <= 16'h0000;
      common_voltage_o <= 8'h00;
    end else begin
      case (op_state_reg)
        epd_pkg::OP_IDLE: begin
          if (is_dat && cmd_reg == `CMD_WR_CEV) common_voltage_o <= b;
          if (sense_go) begin
            op_state_reg <= epd_pkg::OP_SENSE;
            sec_cnt_reg  <= sense_dur_reg;
          end else if (otp_cev || otp_opt || otp_crc) begin
            op_state_reg <= epd_pkg::OP_OTP;
            otp_op_o     <= otp_cev ? epd_pkg::OTP_CEV :
                            otp_opt ? epd_pkg::OTP_OPT : epd_pkg::OTP_CRC;
          end
        end
        epd_pkg::OP_SENSE: if (sec_tick) begin
          if (sec_cnt_reg == 4'h0) begin
            op_state_reg     <= epd_pkg::OP_IDLE;
            common_voltage_o <= sense_value_i;
          end else sec_cnt_reg <= sec_cnt_reg - 4'h1;
        end
        epd_pkg::OP_OTP: if (otp_done_i) begin
          op_state_reg <= epd_pkg::OP_IDLE;
          otp_op_o     <= epd_pkg::OTP_NONE;
          if (otp_op_o == epd_pkg::OTP_CRC) crc_reg <= otp_crc_i;
        end
        default: op_state_reg <= epd_pkg::OP_IDLE;
      endcase
    end
  end
  wire busy_next = seq_go | sense_go | otp_cev | otp_opt | otp_crc |
                   (seq_state_reg != epd_pkg::SEQ_IDLE) | ~op_free;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) busy_o <= 1'b0;
    else busy_o <= busy_next;
  end
  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_clock_turn_on: assert property (
    seq_state_reg == epd_pkg::SEQ_RUN && step_idx_reg == 3'h7 && seq_opt_reg[7]
    |=> clock_enable_flag_o) else $error("clock enable not set");
  a_display_mode_sel: assert property (
    display_start_o |-> display_mode2_o == seq_opt_reg[`SEQ_MODE2_BIT])
    else $error("display mode mismatch");
  a_clock_shut_off: assert property (
    seq_state_reg == epd_pkg::SEQ_RUN && step_idx_reg == 3'h0 && seq_opt_reg[0]
    |=> !clock_enable_flag_o) else $error("clock enable not cleared");
  a_write_addr_step: assert property (
    push && !x_wrap |=> x_reg == $past(x_reg) + 10'h001)
    else $error("address did not advance");
  a_read_dummy_first: assert property (
    cmd_rd |=> tx_hold_reg == 8'h00) else $error("first read byte not dummy");
  a_crc_high_first: assert property (
    cmd_crc |=> tx_hold_reg == $past(crc_reg[15:8])) else $error("crc order wrong");
  a_sense_busy_held: assert property (
    op_state_reg == epd_pkg::OP_SENSE |=> busy_o) else $error("busy low in sensing");
  a_sense_needs_en: assert property (
    $rose(op_state_reg == epd_pkg::OP_SENSE) |-> $past(clock_enable_flag_o)
    && $past(analog_enable_flag_o)) else $error("sense without enables");
  a_border_store: assert property (
    is_dat && cmd_reg == `CMD_BORDER |=> border_drive_output_o == $past(b))
    else $error("border not stored");
  a_seq_busy_held: assert property (
    seq_state_reg != epd_pkg::SEQ_IDLE |=> busy_o) else $error("busy low in sequence");
  c_seq_full: cover property (seq_go ##[1:200] display_start_o);
  c_ram_stall: cover property (stall);
  c_sense_done: cover property (op_state_reg == epd_pkg::OP_SENSE ##1 op_free);
  c_read_data: cover property (dat_rd);
endmodule : epd_controller_command_decoder
`default_nettype wire

/* test/epd_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// host side of the serial link
// ****************************************
module epd_host_model (
  input  wire logic clk_i,
  input  wire logic miso_i,
  output logic      scl_o,
  output logic      mosi_o,
  output logic      cs_n_o,
  output logic      dc_o
);
  initial begin
    scl_o = 1'b0;
    mosi_o = 1'b0;
    cs_n_o = 1'b1;
    dc_o = 1'b1;
  end
  // one byte, msb first; clock stands low between frames
  task automatic xfer(input logic d, input logic [7:0] v, output logic [7:0] q);
    q = 8'h00;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    dc_o   <= d;
    for (int i = 7; i >= 0; i--) begin
      mosi_o <= v[i];
      repeat (4) @(posedge clk_i);
      scl_o <= 1'b1;
      q[i] = miso_i;
      repeat (4) @(posedge clk_i);
      scl_o <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b1;
    mosi_o <= ~mosi_o;
  endtask : xfer
endmodule : epd_host_model
`default_nettype wire

/* test/epd_controller_command_decoder_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module epd_controller_command_decoder_bench;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        scl, mosi, cs_n, dc, so, soe, ln, busy, ce, ae, ds, m2, tl, tf;
  logic        wv, wpl, rpl, pp1, pp2, wr = 1'b0, done = 1'b0;
  logic [9:0]  wx, wy, rx, ry, xs, xe, ox, oe;
  logic [7:0]  wd, cv, ob, bd, q, h, sv = 8'h00;
  logic [1:0]  oop, pm, cur;
  logic [4:0]  idx = 5'h00, ix = 5'h00;
  logic [1:0]  lo = 2'h0;
  logic [15:0] crc = 16'h0000;
  logic [15:0] got[$], exp_q[$];
  int          mismatches = 0, check_count = 0, dn = 0, d0;
  int          tn = 0, fn = 0, bn = 0, t0, f0, b0;
  logic [7:0]  opts[10] = '{8'h80, 8'hC0, 8'h04, 8'h03, 8'hC0, 8'h01, 8'h47, 8'h99, 8'hB9,
                            8'h4F};
  wire  [7:0]  rd = {rpl, rx[6:0]};
  always #50 clk_i = ~clk_i;
  assign ln = soe ? so : mosi;
  epd_host_model epd_host_model_inst (.clk_i(clk_i), .miso_i(ln), .scl_o(scl), .mosi_o(mosi),
    .cs_n_o(cs_n), .dc_o(dc));
  epd_controller_command_decoder #(.CYC_PER_SEC(20)) epd_controller_command_decoder_inst (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(ln), .sda_o(so), .sda_oe_o(soe),
    .cs_n_i(cs_n), .dc_i(dc), .busy_o(busy), .clock_enable_flag_o(ce),
    .analog_enable_flag_o(ae), .display_start_o(ds), .display_mode2_o(m2), .table_load_o(tl),
    .temp_fetch_o(tf), .ram_wr_valid_o(wv), .ram_wr_ready_i(wr), .ram_wr_plane_o(wpl),
    .ram_wr_x_o(wx), .ram_wr_y_o(wy), .ram_wr_data_o(wd), .ram_rd_x_o(rx), .ram_rd_y_o(ry),
    .ram_rd_plane_o(rpl), .ram_rd_data_i(rd), .sense_value_i(sv), .common_voltage_o(cv),
    .otp_op_o(oop), .otp_done_i(done), .otp_crc_i(crc), .otp_byte_idx_i(idx), .otp_byte_o(ob),
    .prog_mode_o(pm), .border_drive_output_o(bd), .pingpong_mode1_o(pp1),
    .pingpong_mode2_o(pp2), .window_x_start_o(xs), .window_x_end_o(xe));
  // receiver stalls at random; otp ops end two cycles after they start
  always @(posedge clk_i) begin
    wr <= ($urandom % 4) != 0;
    idx <= 5'($urandom % 20);
    done <= (oop != 2'h0) && !done;
    if (ds) dn <= dn + 1;
    if (tl) tn <= tn + 1;
    if (tf) fn <= fn + 1;
    if (busy) bn <= bn + 1;
    if (oop != 2'h0) lo <= oop;
    ix <= idx;
    if (wv && wr) got.push_back({wx[5:0], 1'b0, wpl, wd});
  end
  function automatic logic [1:0] flags(input logic [7:0] o, input logic [1:0] c);
    flags[1] = o[0] ? 1'b0 : (o[7] | c[1]);
    flags[0] = o[1] ? 1'b0 : (o[6] | c[0]);
  endfunction : flags
  task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic c(input logic [7:0] v);
    epd_host_model_inst.xfer(1'b0, v, q);
  endtask : c
  task automatic w(input logic [7:0] v);
    epd_host_model_inst.xfer(1'b1, v, q);
  endtask : w
  task automatic final_report();
    $display("mismatches %0d checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  task automatic wait_idle();
    repeat (4) @(posedge clk_i);
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge clk_i);
    if (busy !== 1'b0) begin
      mismatches++;
      final_report();
    end
  endtask : wait_idle
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(18));
    sv = 8'($urandom);
    crc = 16'($urandom);
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check("reset", {bd, pm, 5'h00, rpl}, 16'hC000);
    check("xwin", {xs[5:0], xe}, 16'h03BF);
    cur = 2'h0;
    foreach (opts[k]) begin
      c(8'h22);
      w(opts[k]);
      d0 = dn;
      t0 = tn;
      f0 = fn;
      c(8'h20);
      wait_idle();
      cur = flags(opts[k], cur);
      check("flags", {ce, ae}, cur);
      check("refresh", 16'(dn - d0), {15'h0000, opts[k][2]});
      check("load", 16'(tn - t0), {15'h0000, opts[k][4]});
      check("temp", 16'(fn - f0), {15'h0000, opts[k][5]});
      check("mode2", {15'h0000, m2}, {15'h0000, opts[k][3]});
    end
    c(8'h22);
    w(8'hC0);
    c(8'h20);
    wait_idle();
    c(8'h29);
    w(8'h41);
    b0 = bn;
    c(8'h28);
    wait_idle();
    check("sense", {8'h00, cv}, {8'h00, sv});
    check("sensetime", 16'(bn - b0 >= 40 && bn - b0 <= 42), 16'h0001);
    c(8'h36);
    wait_idle();
    check("otpopt", {14'h0000, lo}, 16'h0002);
    c(8'h2A);
    wait_idle();
    check("otpcev", {14'h0000, lo}, 16'h0001);
    for (int p = 0; p < 2; p++) begin
      c(8'h4E);
      w(8'h00);
      w(8'h00);
      c(p ? 8'h26 : 8'h24);
      for (int k = 0; k < 6; k++) begin
        h = 8'($urandom);
        exp_q.push_back({6'(k), 1'b0, 1'(p), h});
        w(h);
      end
    end
    c(8'h2B);
    w(8'h04);
    w(8'h63);
    check("words", 16'(got.size()), 16'h000C);
    foreach (exp_q[i]) check("word", got[i], exp_q[i]);
    c(8'h41);
    w(8'h01);
    c(8'h27);
    w(8'hFF);
    w(8'hFF);
    check("rdplane", {15'h0000, q[7]}, 16'h0001);
    c(8'h34);
    wait_idle();
    c(8'h35);
    w(8'hFF);
    h = q;
    w(8'hFF);
    check("crc", {h, q}, crc);
    for (int s = 0; s < 4; s++) begin
      h = {2'(s), 6'($urandom)};
      c(8'h3C);
      w(h);
      check("border", {8'h00, bd}, {8'h00, h});
    end
    ox = 10'($urandom);
    oe = 10'($urandom);
    c(8'h44);
    w(ox[7:0]);
    w({6'h00, ox[9:8]});
    w(oe[7:0]);
    w({6'h00, oe[9:8]});
    check("xwin2", {xs[5:0], xe}, {ox[5:0], oe});
    c(8'h39);
    w(8'h03);
    c(8'h37);
    for (int k = 0; k < 10; k++) w(k == 5 ? 8'h80 : 8'h40);
    check("mode", {pm, pp1, pp2}, 16'h000E);
    c(8'h38);
    for (int k = 0; k < 10; k++) w(8'hA0 + 8'(k));
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_i);
      check("optbyte", {8'h00, ob},
            {8'h00, ix < 5'h0A ? (ix == 5'h05 ? 8'h80 : 8'h40) : 8'h96 + 8'(ix)});
    end
    final_report();
  end
endmodule : epd_controller_command_decoder_bench
`default_nettype wire
